/* File: uart_modem_intr_params.svh */
// Offsets, field positions, reset values and counts of the modem and interrupt block.
`ifndef UART_MODEM_INTR_PARAMS_SVH
`define UART_MODEM_INTR_PARAMS_SVH
`define UMI_OFS_ENABLE 8'h04
`define UMI_OFS_IDENT 8'h08
`define UMI_OFS_CONTROL 8'h10
`define UMI_OFS_STATUS 8'h18
`define UMI_EN_RDA 0
`define UMI_EN_THRE 1
`define UMI_EN_RLS 2
`define UMI_EN_MS 3
`define UMI_CTL_DTR 0
`define UMI_CTL_RTS 1
`define UMI_CTL_GPF 2
`define UMI_CTL_GATE 3
`define UMI_CTL_LOOP 4
`define UMI_EN_RESET 4'h0
`define UMI_CTL_RESET 5'h00
`define UMI_CODE_NONE 4'h1
`define UMI_CODE_RLS 4'h6
`define UMI_CODE_RDA 4'h4
`define UMI_CODE_TMO 4'hC
`define UMI_CODE_THRE 4'h2
`define UMI_CODE_MS 4'h0
`define UMI_FIFO_ID 2'h3
`define UMI_TIMEOUT_CHARS 4
`endif

/* File: uart_modem_intr_pkg.sv */
// Types shared by the modem and interrupt block.
package uart_modem_intr_pkg;
   // Modem lines in active-high sense, in status register order.
   typedef struct packed {
      logic dcd;
      logic ri;
      logic dsr;
      logic cts;
   } modem_t;
   typedef logic [3:0] ident_code_t;
endpackage : uart_modem_intr_pkg

/* File: uart_modem_intr.sv */
// Interrupt enable, identification, modem control and modem status logic of a UART.
//
// Behaviour
// RULE1 - Enable bit 0 gates data-available and timeout.
// RULE2 - Enable bit 1 gates transmit-empty interrupt.
// RULE3 - Enable bit 2 gates line status interrupt.
// RULE4 - Enable bit 3 gates modem status interrupt.
// RULE5 - Enable bits 4 to 7 read zero.
// RULE6 - Disabled sources hidden; status flags keep updating.
// RULE7 - Control bit 0 drives terminal-ready pin inverted.
// RULE8 - Control bit 1 drives request-to-send pin inverted.
// RULE9 - Control bit 2 is a pinless flag.
// RULE10 - Control bit 3 gates interrupt request pins.
// RULE11 - Loopback: output marks, input ignored, shifter looped.
// RULE12 - Loopback: modem inputs cut, outputs high, bits feed status.
// RULE13 - Loopback: control bits source modem interrupts.
// RULE14 - Loopback: interrupt request pins float.
// RULE15 - Control bits 5 to 7 read zero.
// RULE16 - Codes: none 0001, line 0110, data 0100.
// RULE17 - Timeout code 1100 after four idle characters.
// RULE18 - Transmit-empty code 0010, cleared by read or write.
// RULE19 - Modem code 0000, cleared by status read.
// RULE20 - Change flags set on edges, clear on read.
// RULE21 - Any change flag raises modem interrupt.
// RULE22 - Status high nibble shows lines or loop bits.
// RULE23 - Identification code frozen during its read.
// RULE24 - Modem inputs synchronised; set beats read clear.
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
`include "uart_modem_intr_params.svh"

module uart_modem_intr #(
   parameter int TIMEOUT_CHARS = `UMI_TIMEOUT_CHARS
) (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic LINE_ERROR,
   input wire logic RX_DATA_READY,
   input wire logic RX_NOT_EMPTY,
   input wire logic RX_PUSH,
   input wire logic RX_POP,
   input wire logic FIFO_MODE,
   input wire logic CHAR_TICK,
   input wire logic THR_EMPTY_EVENT,
   input wire logic THR_WRITE,
   input wire logic TX_SHIFT_OUT,
   input wire logic SERIAL_INPUT,
   input wire logic CTS_N,
   input wire logic DSR_N,
   input wire logic RI_N,
   input wire logic DCD_N,
   output logic SERIAL_OUTPUT,
   output logic RX_SHIFT_IN,
   output logic DTR_N,
   output logic RTS_N,
   output logic INTERRUPT_REQUEST_A_O,
   output logic INTERRUPT_REQUEST_A_OE,
   output logic INTERRUPT_REQUEST_B_O,
   output logic INTERRUPT_REQUEST_B_OE
);

   // The timeout counter is three bits wide, so larger counts cannot be served.
   if (TIMEOUT_CHARS < 1 || TIMEOUT_CHARS > 7) begin : g_bad_timeout
      $error("TIMEOUT_CHARS must lie between 1 and 7.");
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);

   // ==========================================================
   // Bus decode
   // ==========================================================
   logic [3:0] interrupt_enable;
   logic [4:0] modem_control;
   uart_modem_intr_pkg::ident_code_t ident_code;
   uart_modem_intr_pkg::modem_t stat;
   uart_modem_intr_pkg::modem_t prev;
   uart_modem_intr_pkg::modem_t delta;
   logic thre_flag;
   logic tmo_flag;
   logic [2:0] idle_cnt;
   logic [4:0] sync1;
   logic [4:0] sync2;

   // Setup phase samples read data; access phase completes with zero waits.
   wire setup = PSEL && !PENABLE;
   wire done = PSEL && PENABLE && PREADY;
   wire hit_en = PADDR == `UMI_OFS_ENABLE;
   wire hit_id = PADDR == `UMI_OFS_IDENT;
   wire hit_ctl = PADDR == `UMI_OFS_CONTROL;
   wire hit_st = PADDR == `UMI_OFS_STATUS;
   wire mapped = hit_en || hit_id || hit_ctl || hit_st;
   wire wr_en = done && PWRITE && hit_en;
   wire wr_ctl = done && PWRITE && hit_ctl;
   wire rd_id = done && !PWRITE && hit_id;
   wire rd_st = done && !PWRITE && hit_st;
   wire loop = modem_control[`UMI_CTL_LOOP];
   wire [1:0] fifo_id = FIFO_MODE ? `UMI_FIFO_ID : 2'h0;

   // RULE5 upper enable bits zero
   // RULE15 upper control bits zero
   wire [7:0] rd_byte = hit_en ? {4'h0, interrupt_enable} :
                        hit_id ? {fifo_id, 2'h0, ident_code} :
                        hit_ctl ? {3'h0, modem_control} :
                        hit_st ? {stat, delta} : 8'h00;

   // Read data and error are captured in the setup phase so they are
   // steady from flip-flops for the whole access phase.
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         PRDATA <= 32'h0000_0000;
         PSLVERR <= 1'b0;
         PREADY <= 1'b0;
      end else begin
         PREADY <= 1'b1;
         if (setup) begin
            PRDATA <= PWRITE ? 32'h0000_0000 : {24'h00_0000, rd_byte};
            PSLVERR <= !mapped;
         end
      end
   end

   // ==========================================================
   // Control registers
   // ==========================================================
   // RULE1 RULE2 RULE3 RULE4 enable storage
   // RULE9 pinless flag kept
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         interrupt_enable <= `UMI_EN_RESET;
         modem_control <= `UMI_CTL_RESET;
      end else begin
         if (wr_en) begin
            interrupt_enable <= PWDATA[3:0];
         end
         if (wr_ctl) begin
            modem_control <= PWDATA[4:0];
         end
      end
   end

   property p_enable_read;
      setup && !PWRITE && hit_en |=>
         PRDATA[7:4] == 4'h0 && PRDATA[3:0] == $past(interrupt_enable);
   endproperty
   a_enable_read: assert property (p_enable_read) else $error("Enable readback wrong."); // RULE5

   // ==========================================================
   // Pin synchronisers and serial path
   // ==========================================================
   // RULE24 two-stage input sync
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         sync1 <= 5'h1F;
         sync2 <= 5'h1F;
      end else begin
         sync1 <= {SERIAL_INPUT, DCD_N, RI_N, DSR_N, CTS_N};
         sync2 <= sync1;
      end
   end

   // RULE11 loopback serial path
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         SERIAL_OUTPUT <= 1'b1;
         RX_SHIFT_IN <= 1'b1;
      end else begin
         SERIAL_OUTPUT <= loop ? 1'b1 : TX_SHIFT_OUT;
         RX_SHIFT_IN <= loop ? TX_SHIFT_OUT : sync2[4];
      end
   end

   property p_loop_mark;
      loop |=> SERIAL_OUTPUT && RX_SHIFT_IN == $past(TX_SHIFT_OUT);
   endproperty
   a_loop_mark: assert property (p_loop_mark) else $error("Loopback serial path wrong."); // RULE11

   // ==========================================================
   // Modem outputs
   // ==========================================================
   // RULE7 inverted terminal ready
   // RULE8 inverted request to send
   // RULE12 outputs idle high in loopback
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         DTR_N <= 1'b1;
         RTS_N <= 1'b1;
      end else begin
         DTR_N <= loop || !modem_control[`UMI_CTL_DTR];
         RTS_N <= loop || !modem_control[`UMI_CTL_RTS];
      end
   end

   property p_dtr;
      1'b1 |=> DTR_N == ($past(loop) || !$past(modem_control[`UMI_CTL_DTR]));
   endproperty
   a_dtr: assert property (p_dtr) else $error("Terminal ready pin wrong."); // RULE7

   property p_rts;
      1'b1 |=> RTS_N == ($past(loop) || !$past(modem_control[`UMI_CTL_RTS]));
   endproperty
   a_rts: assert property (p_rts) else $error("Request to send pin wrong."); // RULE8

   // ==========================================================
   // Modem status
   // ==========================================================
   // RULE12 loop bits replace the lines
   // RULE22 status nibble source
   wire uart_modem_intr_pkg::modem_t src = loop ?
      {modem_control[`UMI_CTL_GATE], modem_control[`UMI_CTL_GPF],
       modem_control[`UMI_CTL_DTR], modem_control[`UMI_CTL_RTS]} :
      ~sync2[3:0];

   // RULE20 edge detection per line
   // RULE13 control bits raise changes in loopback
   // Ring flags only the trailing edge: line active, then released.
   wire uart_modem_intr_pkg::modem_t chg = {stat.dcd ^ prev.dcd, prev.ri && !stat.ri,
                                           stat.dsr ^ prev.dsr, stat.cts ^ prev.cts};

   // A change in the very cycle of a status read survives the clear.
   // RULE24 set beats read clear
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         stat <= '0;
         prev <= '0;
         delta <= '0;
      end else begin
         stat <= src;
         prev <= stat;
         delta <= (rd_st ? 4'h0 : delta) | chg;
      end
   end

   property p_status_clear;
      rd_st && chg == 4'h0 |=> delta == 4'h0;
   endproperty
   a_status_clear: assert property (p_status_clear) else $error("Change flags not cleared."); // RULE20

   property p_status_keep;
      rd_st && chg.cts |=> delta.cts;
   endproperty
   a_status_keep: assert property (p_status_keep) else $error("Change lost on read."); // RULE24

   // The write must keep loopback on, or the source switches back to the pins.
   sequence s_cts_toggle;
      loop && wr_ctl && PWDATA[`UMI_CTL_LOOP] && !rd_st &&
         PWDATA[`UMI_CTL_RTS] != modem_control[`UMI_CTL_RTS] ##1 !rd_st[*3];
   endsequence
   property p_loop_delta;
      s_cts_toggle |=> delta.cts;
   endproperty
   a_loop_delta: assert property (p_loop_delta) else $error("Loop change not flagged."); // RULE13

   // ==========================================================
   // Interrupt sources
   // ==========================================================
   // RULE17 idle character counter
   wire activity = RX_PUSH || RX_POP || !RX_NOT_EMPTY || !FIFO_MODE;
   wire reached = idle_cnt == 3'(TIMEOUT_CHARS);
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         idle_cnt <= 3'h0;
      end else if (activity) begin
         idle_cnt <= 3'h0;
      end else if (CHAR_TICK && !reached) begin
         idle_cnt <= idle_cnt + 3'h1;
      end
   end

   // RULE17 timeout set, cleared by buffer read
   // RULE18 transmit empty set and clears
   wire thre_read_clr = rd_id && ident_code == `UMI_CODE_THRE;
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         tmo_flag <= 1'b0;
         thre_flag <= 1'b0;
      end else begin
         tmo_flag <= (reached && !activity) || (tmo_flag && !RX_POP && FIFO_MODE);
         thre_flag <= THR_EMPTY_EVENT || (thre_flag && !THR_WRITE && !thre_read_clr);
      end
   end

   property p_timeout;
      reached && !activity |=> tmo_flag;
   endproperty
   a_timeout: assert property (p_timeout) else $error("Timeout not raised."); // RULE17

   property p_thre_clr;
      THR_WRITE && !THR_EMPTY_EVENT |=> !thre_flag;
   endproperty
   a_thre_clr: assert property (p_thre_clr) else $error("Transmit empty not cleared."); // RULE18

   // RULE6 enables gate each source
   // RULE1 data and timeout share bit 0
   wire rls_p = LINE_ERROR && interrupt_enable[`UMI_EN_RLS];
   wire rda_p = RX_DATA_READY && interrupt_enable[`UMI_EN_RDA];
   wire tmo_p = tmo_flag && interrupt_enable[`UMI_EN_RDA];
   wire thr_p = thre_flag && interrupt_enable[`UMI_EN_THRE];
   // RULE21 any change flag pends
   wire ms_p = |delta && interrupt_enable[`UMI_EN_MS];

   // RULE16 RULE19 priority encoding
   wire uart_modem_intr_pkg::ident_code_t next_code = rls_p ? `UMI_CODE_RLS :
                                                   rda_p ? `UMI_CODE_RDA :
                                                   tmo_p ? `UMI_CODE_TMO :
                                                   thr_p ? `UMI_CODE_THRE :
                                                   ms_p ? `UMI_CODE_MS : `UMI_CODE_NONE;

   // Sources keep latching below; only the reported code holds while
   // the host has the identification register selected for a read.
   // RULE23 freeze during access
   wire freeze = PSEL && hit_id && !PWRITE;
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         ident_code <= `UMI_CODE_NONE;
      end else if (!freeze) begin
         ident_code <= next_code;
      end
   end

   property p_freeze;
      freeze && $past(freeze) |-> $stable(ident_code);
   endproperty
   a_freeze: assert property (p_freeze) else $error("Code moved during read."); // RULE23

   property p_none;
      !freeze && !(rls_p || rda_p || tmo_p || thr_p || ms_p) |=> ident_code == `UMI_CODE_NONE;
   endproperty
   a_none: assert property (p_none) else $error("Idle code wrong."); // RULE16

   property p_disabled;
      !interrupt_enable[`UMI_EN_THRE] && !freeze |=> ident_code != `UMI_CODE_THRE;
   endproperty
   a_disabled: assert property (p_disabled) else $error("Disabled source shown."); // RULE6

   property p_ms_code;
      !freeze && ms_p && !(rls_p || rda_p || tmo_p || thr_p) |=> ident_code == `UMI_CODE_MS;
   endproperty
   a_ms_code: assert property (p_ms_code) else $error("Modem code wrong."); // RULE21

   // ==========================================================
   // Interrupt request pins
   // ==========================================================
   // RULE10 gate bit drives pins
   // RULE14 pins float in loopback
   wire irq = next_code != `UMI_CODE_NONE && modem_control[`UMI_CTL_GATE];
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         INTERRUPT_REQUEST_A_O <= 1'b0;
         INTERRUPT_REQUEST_B_O <= 1'b0;
         INTERRUPT_REQUEST_A_OE <= 1'b0;
         INTERRUPT_REQUEST_B_OE <= 1'b0;
      end else begin
         INTERRUPT_REQUEST_A_O <= irq;
         INTERRUPT_REQUEST_B_O <= irq;
         INTERRUPT_REQUEST_A_OE <= !loop;
         INTERRUPT_REQUEST_B_OE <= !loop;
      end
   end

   property p_gate;
      INTERRUPT_REQUEST_A_O |-> $past(modem_control[`UMI_CTL_GATE]);
   endproperty
   a_gate: assert property (p_gate) else $error("Request without gate."); // RULE10

   property p_float;
      loop ##1 loop |-> !INTERRUPT_REQUEST_A_OE && !INTERRUPT_REQUEST_B_OE;
   endproperty
   a_float: assert property (p_float) else $error("Request pins driven in loopback."); // RULE14

endmodule : uart_modem_intr

/* File: modem_partner.sv */
// Behavioural modem that drives the four active-low handshake pins.
module modem_partner #(
   parameter int LAG = 1
) (
   input wire logic clk,
   input wire uart_modem_intr_pkg::modem_t lines,
   output logic cts_n,
   output logic dsr_n,
   output logic ri_n,
   output logic dcd_n
);
   timeunit 1ns;
   timeprecision 100ps;
   uart_modem_intr_pkg::modem_t hist [0:7];
   // A short delay line lets the modem answer late, as a slow data set would.
   always_ff @(posedge clk) begin
      hist[0] <= lines;
      for (int i = 1; i < 8; i++) begin
         hist[i] <= hist[i - 1];
      end
   end
   // The pins are active low, so the requested levels are inverted.
   assign cts_n = ~hist[LAG - 1].cts;
   assign dsr_n = ~hist[LAG - 1].dsr;
   assign ri_n = ~hist[LAG - 1].ri;
   assign dcd_n = ~hist[LAG - 1].dcd;
endmodule : modem_partner

/* File: uart_modem_interrupt_logic_tb_top.sv */
// Self-checking bench of the modem and interrupt block driven over APB.
`include "uart_modem_intr_params.svh"
module uart_modem_interrupt_logic_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int TMO = 4;
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic lerr, rdr, rne, push, pop, fifo, tick, thre, thw, txo, serial_input, so, rxi;
   logic cts_n, dsr_n, ri_n, dcd_n, dtr_n, rts_n, ia, iae, ib, ibe;
   uart_modem_intr_pkg::modem_t lines;
   int n_mismatch, n_tests;

   uart_modem_intr #(.TIMEOUT_CHARS(TMO)) uut (.CLK(clk), .RST_N(rst_n), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .LINE_ERROR(lerr), .RX_DATA_READY(rdr),
      .RX_NOT_EMPTY(rne), .RX_PUSH(push), .RX_POP(pop), .FIFO_MODE(fifo), .CHAR_TICK(tick),
      .THR_EMPTY_EVENT(thre), .THR_WRITE(thw), .TX_SHIFT_OUT(txo), .SERIAL_INPUT(serial_input),
      .CTS_N(cts_n), .DSR_N(dsr_n), .RI_N(ri_n), .DCD_N(dcd_n), .SERIAL_OUTPUT(so),
      .RX_SHIFT_IN(rxi), .DTR_N(dtr_n), .RTS_N(rts_n), .INTERRUPT_REQUEST_A_O(ia),
      .INTERRUPT_REQUEST_A_OE(iae), .INTERRUPT_REQUEST_B_O(ib),
      .INTERRUPT_REQUEST_B_OE(ibe));
   modem_partner #(.LAG(2)) modem (.clk(clk), .lines(lines), .cts_n(cts_n),
      .dsr_n(dsr_n), .ri_n(ri_n), .dcd_n(dcd_n));

   // ==========================================
   // Clock and shared tasks
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic complete_run();
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : complete_run

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // One APB transfer; the request is held until pready is seen high.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (i = 0; i < 16; i++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (i == 16) begin
         n_mismatch++;
         complete_run();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Upper write lanes carry ones, which the block must ignore.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'hFFFFFF, d});
   endtask : wr

   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, {24'h0, e});
   endtask : rdc

   // Strobes the inputs selected by the mask {thre, thw, tick, pop} for one cycle.
   task automatic pulse(input logic [3:0] m);
      @(posedge clk);
      {thre, thw, tick, pop} <= m;
      @(posedge clk);
      {thre, thw, tick, pop} <= 4'h0;
   endtask : pulse

   // Modem changes need a few edges to cross the synchronisers.
   task automatic settle();
      repeat (8) @(posedge clk);
   endtask : settle

   // ==========================================
   // Main sequence
   initial begin
      {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
      {lerr, rdr, rne, push, pop, fifo, tick, thre, thw, txo} = '0;
      serial_input = 1'b1;
      lines = '0;
      n_mismatch = 0;
      n_tests = 0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      // Reset values and masked bits.
      rdc(`UMI_OFS_ENABLE, 8'h00);
      rdc(`UMI_OFS_CONTROL, 8'h00);
      rdc(`UMI_OFS_IDENT, 8'h01);
      wr(`UMI_OFS_ENABLE, 8'hFF);
      rdc(`UMI_OFS_ENABLE, 8'h0F);
      wr(`UMI_OFS_CONTROL, 8'hE3);
      rdc(`UMI_OFS_CONTROL, 8'h03);
      @(negedge clk);
      chk({dtr_n, rts_n}, 32'h0);
      wr(`UMI_OFS_CONTROL, 8'h0C);
      rdc(`UMI_OFS_CONTROL, 8'h0C);
      @(negedge clk);
      chk({dtr_n, rts_n}, 32'h3);
      // Priority of line, data and transmit sources.
      @(posedge clk);
      lerr <= 1'b1;
      rdr <= 1'b1;
      rdc(`UMI_OFS_IDENT, 8'h06);
      @(negedge clk);
      chk({ia, iae, ib, ibe}, 32'hF);
      @(posedge clk);
      lerr <= 1'b0;
      rdc(`UMI_OFS_IDENT, 8'h04);
      rdr <= 1'b0;
      pulse(4'h8);
      rdc(`UMI_OFS_IDENT, 8'h02);
      rdc(`UMI_OFS_IDENT, 8'h01);
      pulse(4'h8);
      pulse(4'h4);
      rdc(`UMI_OFS_IDENT, 8'h01);
      // Gate bit and per-source enables.
      wr(`UMI_OFS_CONTROL, 8'h04);
      lerr <= 1'b1;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk({ia, iae}, 32'h1);
      wr(`UMI_OFS_ENABLE, 8'h09);
      rdc(`UMI_OFS_IDENT, 8'h01);
      lerr <= 1'b0;
      pulse(4'h8);
      rdc(`UMI_OFS_IDENT, 8'h01);
      wr(`UMI_OFS_ENABLE, 8'h0B);
      rdc(`UMI_OFS_IDENT, 8'h02);
      // Modem change flags and status nibble.
      wr(`UMI_OFS_CONTROL, 8'h08);
      lines.cts <= 1'b1;
      settle();
      rdc(`UMI_OFS_IDENT, 8'h00);
      rdc(`UMI_OFS_STATUS, 8'h11);
      rdc(`UMI_OFS_STATUS, 8'h10);
      rdc(`UMI_OFS_IDENT, 8'h01);
      lines.ri <= 1'b1;
      settle();
      rdc(`UMI_OFS_STATUS, 8'h50);
      lines.ri <= 1'b0;
      settle();
      rdc(`UMI_OFS_STATUS, 8'h14);
      lines <= 4'b1010;
      settle();
      rdc(`UMI_OFS_STATUS, 8'hAB);
      lines <= 4'b0000;
      settle();
      rdc(`UMI_OFS_STATUS, 8'h0A);
      wr(`UMI_OFS_ENABLE, 8'h07);
      lines.cts <= 1'b1;
      settle();
      rdc(`UMI_OFS_IDENT, 8'h01);
      rdc(`UMI_OFS_STATUS, 8'h11);
      lines.cts <= 1'b0;
      settle();
      rdc(`UMI_OFS_STATUS, 8'h01);
      // The flag lands on the access edge of this read, so it must survive it.
      lines.cts <= 1'b1;
      repeat (3) @(posedge clk);
      rdc(`UMI_OFS_STATUS, 8'h00);
      rdc(`UMI_OFS_STATUS, 8'h11);
      lines.cts <= 1'b0;
      settle();
      rdc(`UMI_OFS_STATUS, 8'h01);
      // Character timeout in FIFO mode.
      wr(`UMI_OFS_ENABLE, 8'h01);
      fifo <= 1'b1;
      rne <= 1'b1;
      for (int k = 0; k < TMO - 1; k++) pulse(4'h2);
      rdc(`UMI_OFS_IDENT, 8'hC1);
      pulse(4'h2);
      // The flag needs one more edge before the code register can take it.
      @(posedge clk);
      rdc(`UMI_OFS_IDENT, 8'hCC);
      pulse(4'h1);
      rdc(`UMI_OFS_IDENT, 8'hC1);
      fifo <= 1'b0;
      rne <= 1'b0;
      // Normal serial path: output follows the shifter, input follows the pin.
      serial_input <= 1'b0;
      txo <= 1'b1;
      settle();
      @(negedge clk);
      chk({so, rxi}, 32'h2);
      // Loopback: pins parked, control bits feed the status.
      wr(`UMI_OFS_ENABLE, 8'h08);
      wr(`UMI_OFS_CONTROL, 8'h11);
      lines.cts <= 1'b1;
      serial_input <= 1'b0;
      txo <= 1'b1;
      settle();
      rdc(`UMI_OFS_IDENT, 8'h00);
      rdc(`UMI_OFS_STATUS, 8'h22);
      @(negedge clk);
      chk({so, rxi, dtr_n, rts_n, iae, ibe}, 32'h3C);
      wr(`UMI_OFS_CONTROL, 8'h1E);
      settle();
      rdc(`UMI_OFS_STATUS, 8'hDB);
      // Unmapped address is refused.
      apb(1'b0, 8'h40, 32'h0);
      chk(rd, 32'h0);
      chk({31'h0, err}, 32'h1);
      complete_run();
   end
endmodule : uart_modem_interrupt_logic_tb_top
